//--- core/smi_group_pkg.sv
// Summary of operation
// - Status A latches pins 30-33,41,fan,43,61
// - Status writes of one clear, zero keeps
// - Status B latches pins 50 to 57
// - Status C latches pins 10 to 17
// - Enable one passes source, zero blocks it
// - Peripheral enable gates parallel, midi, serial, floppy, watchdog
// - Misc enable gates mouse, keyboard, smbus, ring, port12
// - Misc bit 6 routes group onto serial IRQ
// - Misc bit 7 drives pin, else pin floats
// - Pin enable A gates pins 20-27 group
// - Misc enable register resets to zero
// - Mouse and keyboard clear only at source
package smi_group_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_STS_A  = 8'h13;
  localparam logic [7:0] OFS_STS_B  = 8'h14;
  localparam logic [7:0] OFS_STS_C  = 8'h15;
  localparam logic [7:0] OFS_EN_PER = 8'h16;
  localparam logic [7:0] OFS_EN_MSC = 8'h17;
  localparam logic [7:0] OFS_EN_PA  = 8'h18;
  localparam logic [7:0] OFS_MSK_A  = 8'h19;
  localparam logic [7:0] OFS_MSK_B  = 8'h1A;
  localparam logic [7:0] OFS_MSK_C  = 8'h1B;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_STANDBY   = 8'h00;
  localparam logic [7:0] RST_STS_A_MAIN = 8'h08;
  localparam logic [7:0] RST_ENABLE    = 8'h00;
  localparam logic [7:0] RD_UNMAPPED   = 8'h00;

  // ----------------------------------------------------------------
  // Writable bit masks, reserved bits stay zero
  // ----------------------------------------------------------------
  localparam logic [7:0] WMASK_EN_PER = 8'h9E;
  localparam logic [7:0] WMASK_EN_MSC = 8'hDF;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int PER_PARALLEL = 1;
  localparam int PER_MIDI     = 2;
  localparam int PER_SERIAL1  = 3;
  localparam int PER_FLOPPY   = 4;
  localparam int PER_WATCHDOG = 7;
  localparam int MSC_MOUSE    = 0;
  localparam int MSC_KEYBOARD = 1;
  localparam int MSC_SMBUS    = 2;
  localparam int MSC_RING     = 3;
  localparam int MSC_PORT12   = 4;
  localparam int MSC_SERIRQ   = 6;
  localparam int MSC_PIN      = 7;
  localparam int STS_A_FAN    = 5;

  // Number of synchronised event pins across the three status registers
  localparam int PIN_COUNT = 24;

endpackage : smi_group_pkg

//--- core/pin_sync.sv
`timescale 1ns/1ps
module pin_sync
  import smi_group_pkg::*;
(
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  // Asynchronous pins and their synchronised levels
  input  wire logic [PIN_COUNT-1:0] pinAsync,
  output logic      [PIN_COUNT-1:0] pinSync
);

  logic [PIN_COUNT-1:0] stage1_r;

  // Two flops per pin; only the second stage looks at the first
  genvar i;
  generate
    for (i = 0; i < PIN_COUNT; i++) begin : g_sync
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          stage1_r[i] <= 1'b0;
          pinSync[i]  <= 1'b0;
        end else begin
          stage1_r[i] <= pinAsync[i];
          pinSync[i]  <= stage1_r[i];
        end
      end
    end
  endgenerate

endmodule : pin_sync

//--- core/status_w1c.sv
`timescale 1ns/1ps
module status_w1c
  import smi_group_pkg::*;
#(
  parameter logic [7:0] MAIN_VAL = RST_STANDBY
) (
  // Clock and resets
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       mainRst_n,
  // Hardware set and software clear
  input  wire logic [7:0] setBits,
  input  wire logic [7:0] clrBits,
  // Stored status
  output logic      [7:0] stsQ
);

  // One sticky flop per bit; a set in the clear cycle wins
  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_bit
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          stsQ[i] <= RST_STANDBY[i];
        end else if (!mainRst_n) begin
          stsQ[i] <= MAIN_VAL[i];
        end else if (setBits[i]) begin
          stsQ[i] <= 1'b1;
        end else if (clrBits[i]) begin
          stsQ[i] <= 1'b0;
        end
      end
    end
  endgenerate

endmodule : status_w1c

//--- core/smi_status_enable_group.sv
`timescale 1ns/1ps
module smi_status_enable_group
  import smi_group_pkg::*;
(
  // Clock and standby-power reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Main-power reset or hard reset, same clock, active low
  input  wire logic       mainRst_n,

  // Register port
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWrData,
  input  wire logic       regWrStb,
  input  wire logic       regRdStb,
  output logic      [7:0] regRdData,

  // Event pins for status A, asynchronous
  input  wire logic       gp30,
  input  wire logic       gp31,
  input  wire logic       gp32,
  input  wire logic       gp33,
  input  wire logic       gp41,
  input  wire logic       fanSpeedInput,
  input  wire logic       gp43,
  input  wire logic       gp61,
  // Event pins for status B and C, asynchronous, bit 0 lowest pin
  input  wire logic [7:0] gp5x,
  input  wire logic [7:0] gp1x,

  // On-chip peripheral interrupts, same clock, active high levels
  input  wire logic       parallelIrq,
  input  wire logic       midiUartIrq,
  input  wire logic       serial1Irq,
  input  wire logic       floppyIrq,
  input  wire logic       watchdogIrq,
  input  wire logic       mouseIrq,
  input  wire logic       keyboardIrq,
  input  wire logic       smbusIrq,
  input  wire logic       ringIndicator,
  input  wire logic       port12Event,
  // Latched pin events 20-27 from the neighbouring status, same clock
  input  wire logic [7:0] pinEventA,

  // Output buffer type of the group pin: 1 push-pull, 0 open-drain
  input  wire logic       pinPushPull,

  // Group line and its routes
  output logic            groupMgmtIrq_n,
  output logic            mgmtIrqOutPin,
  output logic            mgmtIrqOutPinOe,
  output logic            routeGroupToSerirq,
  // Interrupt of the pin-event status registers
  output logic            irq
);

  // ----------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------
  logic [PIN_COUNT-1:0] pinAsync;
  logic [PIN_COUNT-1:0] pinSync;
  logic [PIN_COUNT-1:0] pinPrev_r;
  logic [PIN_COUNT-1:0] pinRise;

  // Status A layout, then status B and status C
  assign pinAsync = {gp1x, gp5x,
                     gp61, gp43, fanSpeedInput, gp41,
                     gp33, gp32, gp31, gp30};

  pin_sync u_sync (
    .clk      (clk),
    .rst_n    (rst_n),
    .pinAsync (pinAsync),
    .pinSync  (pinSync)
  );

  // Previous level; reset to zero so a pin high at release counts once
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pinPrev_r <= '0;
    end else begin
      pinPrev_r <= pinSync;
    end
  end

  // A rising edge of a pin is its event
  assign pinRise = pinSync & ~pinPrev_r;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic wrStsA;
  logic wrStsB;
  logic wrStsC;
  logic wrEnPer;
  logic wrEnMsc;
  logic wrEnPa;
  logic wrMskA;
  logic wrMskB;
  logic wrMskC;

  // Write hits per register
  assign wrStsA  = regWrStb && (regAddr == OFS_STS_A);
  assign wrStsB  = regWrStb && (regAddr == OFS_STS_B);
  assign wrStsC  = regWrStb && (regAddr == OFS_STS_C);
  assign wrEnPer = regWrStb && (regAddr == OFS_EN_PER);
  assign wrEnMsc = regWrStb && (regAddr == OFS_EN_MSC);
  assign wrEnPa  = regWrStb && (regAddr == OFS_EN_PA);
  assign wrMskA  = regWrStb && (regAddr == OFS_MSK_A);
  assign wrMskB  = regWrStb && (regAddr == OFS_MSK_B);
  assign wrMskC  = regWrStb && (regAddr == OFS_MSK_C);

  // ----------------------------------------------------------------
  // Pin-event status registers
  // ----------------------------------------------------------------
  logic [7:0] stsA;
  logic [7:0] stsB;
  logic [7:0] stsC;
  logic [7:0] clrA;
  logic [7:0] clrB;
  logic [7:0] clrC;

  // A one written clears, a zero leaves the bit alone
  assign clrA = wrStsA ? regWrData : 8'h00;
  assign clrB = wrStsB ? regWrData : 8'h00;
  assign clrC = wrStsC ? regWrData : 8'h00;

  // Status A also takes its main-power value on main reset
  status_w1c #(
    .MAIN_VAL (RST_STS_A_MAIN)
  ) u_sts_a (
    .clk       (clk),
    .rst_n     (rst_n),
    .mainRst_n (mainRst_n),
    .setBits   (pinRise[7:0]),
    .clrBits   (clrA),
    .stsQ      (stsA)
  );

  // Status B keeps its state across main reset
  status_w1c #(
    .MAIN_VAL (RST_STANDBY)
  ) u_sts_b (
    .clk       (clk),
    .rst_n     (rst_n),
    .mainRst_n (1'b1),
    .setBits   (pinRise[15:8]),
    .clrBits   (clrB),
    .stsQ      (stsB)
  );

  // Status C keeps its state across main reset
  status_w1c #(
    .MAIN_VAL (RST_STANDBY)
  ) u_sts_c (
    .clk       (clk),
    .rst_n     (rst_n),
    .mainRst_n (1'b1),
    .setBits   (pinRise[23:16]),
    .clrBits   (clrC),
    .stsQ      (stsC)
  );

  // ----------------------------------------------------------------
  // Enable registers
  // ----------------------------------------------------------------
  logic [7:0] enPer_r;
  logic [7:0] enMsc_r;
  logic [7:0] enPa_r;

  // Peripheral gates; reserved bits cannot be set
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      enPer_r <= RST_ENABLE;
    end else if (wrEnPer) begin
      enPer_r <= regWrData & WMASK_EN_PER;
    end
  end

  // Misc gates and both routes start disabled
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      enMsc_r <= RST_ENABLE;
    end else if (wrEnMsc) begin
      enMsc_r <= regWrData & WMASK_EN_MSC;
    end
  end

  // Gates for pin events 20 to 27
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      enPa_r <= RST_ENABLE;
    end else if (wrEnPa) begin
      enPa_r <= regWrData;
    end
  end

  // ----------------------------------------------------------------
  // Mask registers for the status registers
  // ----------------------------------------------------------------
  logic [7:0] mskA_r;
  logic [7:0] mskB_r;
  logic [7:0] mskC_r;

  // Same layout as the matching status register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mskA_r <= RST_ENABLE;
      mskB_r <= RST_ENABLE;
      mskC_r <= RST_ENABLE;
    end else begin
      if (wrMskA) begin
        mskA_r <= regWrData;
      end
      if (wrMskB) begin
        mskB_r <= regWrData;
      end
      if (wrMskC) begin
        mskC_r <= regWrData;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read back
  // ----------------------------------------------------------------
  logic [7:0] rdMux;

  // Unmapped offsets read as zero
  always_comb begin
    case (regAddr)
      OFS_STS_A:  rdMux = stsA;
      OFS_STS_B:  rdMux = stsB;
      OFS_STS_C:  rdMux = stsC;
      OFS_EN_PER: rdMux = enPer_r;
      OFS_EN_MSC: rdMux = enMsc_r;
      OFS_EN_PA:  rdMux = enPa_r;
      OFS_MSK_A:  rdMux = mskA_r;
      OFS_MSK_B:  rdMux = mskB_r;
      OFS_MSK_C:  rdMux = mskC_r;
      default:    rdMux = RD_UNMAPPED;
    endcase
  end

  // Data stands only in the cycle after the read strobe
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      regRdData <= RD_UNMAPPED;
    end else if (regRdStb) begin
      regRdData <= rdMux;
    end else begin
      regRdData <= RD_UNMAPPED;
    end
  end

  // ----------------------------------------------------------------
  // Source gating
  // ----------------------------------------------------------------
  logic [7:0] perSrc;
  logic [4:0] mscSrc;
  logic       perHit;
  logic       mscHit;
  logic       pinHit;
  logic       stsHit;
  logic       groupActive;

  // Peripheral sources placed at their enable bit positions
  always_comb begin
    perSrc               = 8'h00;
    perSrc[PER_PARALLEL] = parallelIrq;
    perSrc[PER_MIDI]     = midiUartIrq;
    perSrc[PER_SERIAL1]  = serial1Irq;
    perSrc[PER_FLOPPY]   = floppyIrq;
    perSrc[PER_WATCHDOG] = watchdogIrq;
  end

  // Mouse and keyboard are levels owned by their source: nothing here
  // latches them, so only the source can take them away
  always_comb begin
    mscSrc               = 5'h00;
    mscSrc[MSC_MOUSE]    = mouseIrq;
    mscSrc[MSC_KEYBOARD] = keyboardIrq;
    mscSrc[MSC_SMBUS]    = smbusIrq;
    mscSrc[MSC_RING]     = ringIndicator;
    mscSrc[MSC_PORT12]   = port12Event;
  end

  // One passes a source, zero blocks it
  assign perHit = |(perSrc & enPer_r);
  assign mscHit = |(mscSrc & enMsc_r[4:0]);
  assign pinHit = |(pinEventA & enPa_r);
  assign stsHit = |(stsA & mskA_r) |
                  |(stsB & mskB_r) |
                  |(stsC & mskC_r);

  // Any enabled source holds the group active
  assign groupActive = perHit | mscHit | pinHit | stsHit;

  // ----------------------------------------------------------------
  // Group line and routes
  // ----------------------------------------------------------------

  // Group line, active low; registered so it cannot glitch
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      groupMgmtIrq_n <= 1'b1;
    end else begin
      groupMgmtIrq_n <= ~groupActive;
    end
  end

  // Serial IRQ request only while the route is enabled
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      routeGroupToSerirq <= 1'b0;
    end else begin
      routeGroupToSerirq <= enMsc_r[MSC_SERIRQ] & groupActive;
    end
  end

  // Pin drive: push-pull drives both levels, open-drain only pulls low;
  // with the route off the pin floats in either buffer type
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mgmtIrqOutPin   <= 1'b1;
      mgmtIrqOutPinOe <= 1'b0;
    end else if (!enMsc_r[MSC_PIN]) begin
      mgmtIrqOutPin   <= 1'b1;
      mgmtIrqOutPinOe <= 1'b0;
    end else if (pinPushPull) begin
      mgmtIrqOutPin   <= ~groupActive;
      mgmtIrqOutPinOe <= 1'b1;
    end else begin
      mgmtIrqOutPin   <= 1'b0;
      mgmtIrqOutPinOe <= groupActive;
    end
  end

  // ----------------------------------------------------------------
  // Status interrupt
  // ----------------------------------------------------------------

  // Level output, high while an unmasked status bit is set
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= stsHit;
    end
  end

endmodule : smi_status_enable_group

//--- bench/smi_group_chk.sv
`timescale 1ns/1ps
module smi_group_chk
  import smi_group_pkg::*;
(
  // Clock and reset
  input wire logic       clk,
  input wire logic       rst_n,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic       regWrStb,
  input wire logic       regRdStb,
  input wire logic [7:0] regRdData,
  // Sources and group outputs
  input wire logic       mouseIrq,
  input wire logic       pinPushPull,
  input wire logic       groupMgmtIrq_n,
  input wire logic       mgmtIrqOutPin,
  input wire logic       mgmtIrqOutPinOe,
  input wire logic       routeGroupToSerirq,
  input wire logic       irq
);
  // ----
  // Shadow of the misc enable
  // ----
  // Rebuilt from bus writes so gating is checked from the ports alone
  logic [7:0] enMsc_r;
  always_ff @(posedge clk) begin
    if (!rst_n)
      enMsc_r <= 8'h00;
    else if (regWrStb && regAddr == OFS_EN_MSC)
      enMsc_r <= regWrData & WMASK_EN_MSC;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Read steps: strobe cycle, then the single data cycle
  sequence rdMisc;
    regRdStb && regAddr == OFS_EN_MSC;
  endsequence
  sequence rdHole;
    regRdStb && (regAddr < OFS_STS_A || regAddr > OFS_MSK_C);
  endsequence

  rd_idle_a: assert property (!regRdStb |=> regRdData == 8'h00)
    else $error("read data not zero outside read cycle");
  rd_hole_a: assert property (rdHole |=> regRdData == RD_UNMAPPED)
    else $error("unmapped read not zero");
  misc_read_a: assert property (rdMisc |=> regRdData == $past(enMsc_r))
    else $error("misc enable readback wrong");
  mouse_gate_a: assert property (
    mouseIrq && enMsc_r[MSC_MOUSE] |=> !groupMgmtIrq_n)
    else $error("enabled mouse source not on group line");
  pin_float_a: assert property (
    !enMsc_r[MSC_PIN] |=> !mgmtIrqOutPinOe && mgmtIrqOutPin)
    else $error("group pin driven while route off");
  od_drive_a: assert property (
    mgmtIrqOutPinOe && !$past(pinPushPull) |->
      !mgmtIrqOutPin && !groupMgmtIrq_n)
    else $error("open-drain pin driven wrongly");
  pp_drive_a: assert property (
    mgmtIrqOutPinOe && $past(pinPushPull) |->
      mgmtIrqOutPin == groupMgmtIrq_n)
    else $error("push-pull pin value wrong");
  serirq_on_a: assert property (
    enMsc_r[MSC_SERIRQ] |=> routeGroupToSerirq == !groupMgmtIrq_n)
    else $error("serial route does not follow group");
  serirq_off_a: assert property (
    !enMsc_r[MSC_SERIRQ] |=> !routeGroupToSerirq)
    else $error("serial route active while disabled");
  irq_group_a: assert property (irq |-> !groupMgmtIrq_n)
    else $error("irq without group line");
endmodule : smi_group_chk

//--- bench/smi_host_sink.sv
`timescale 1ns/1ps
module smi_host_sink (
  // Pin from the block
  input  wire logic mgmtIrqOutPin,
  input  wire logic mgmtIrqOutPinOe,
  input  wire logic routeGroupToSerirq,
  // What the host sees
  output logic      smiWireLevel,
  output logic      serirqSlot
);
  // Board pull-up: a floating or released line reads high
  assign smiWireLevel = mgmtIrqOutPinOe ? mgmtIrqOutPin : 1'b1;
  // Serial slot follows the route request level
  assign serirqSlot   = routeGroupToSerirq;
endmodule : smi_host_sink

//--- bench/tb.sv
`timescale 1ns/1ps
module tb;
  import smi_group_pkg::*;
  // ----
  // Signals and reference model
  // ----
  logic       clk, rst_n, mainRst_n, regWrStb, regRdStb, pinPushPull;
  logic [7:0] regAddr, regWrData, regRdData, gpA, gp5x, gp1x, pinEventA;
  logic [4:0] perIrq, mscIrq;
  logic       groupMgmtIrq_n, mgmtIrqOutPin, mgmtIrqOutPinOe;
  logic       routeGroupToSerirq, irq, smiWireLevel, serirqSlot;
  logic [7:0] mReg [0:8];
  int         n_fail, n_checks;

  smi_status_enable_group smi_status_enable_group_inst (
    .clk(clk), .rst_n(rst_n), .mainRst_n(mainRst_n),
    .regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb),
    .regRdStb(regRdStb), .regRdData(regRdData),
    .gp30(gpA[0]), .gp31(gpA[1]), .gp32(gpA[2]), .gp33(gpA[3]),
    .gp41(gpA[4]), .fanSpeedInput(gpA[5]), .gp43(gpA[6]), .gp61(gpA[7]),
    .gp5x(gp5x), .gp1x(gp1x),
    .parallelIrq(perIrq[0]), .midiUartIrq(perIrq[1]),
    .serial1Irq(perIrq[2]), .floppyIrq(perIrq[3]),
    .watchdogIrq(perIrq[4]), .mouseIrq(mscIrq[0]),
    .keyboardIrq(mscIrq[1]), .smbusIrq(mscIrq[2]),
    .ringIndicator(mscIrq[3]), .port12Event(mscIrq[4]),
    .pinEventA(pinEventA), .pinPushPull(pinPushPull),
    .groupMgmtIrq_n(groupMgmtIrq_n), .mgmtIrqOutPin(mgmtIrqOutPin),
    .mgmtIrqOutPinOe(mgmtIrqOutPinOe),
    .routeGroupToSerirq(routeGroupToSerirq), .irq(irq));

  smi_host_sink smi_host_sink_inst (
    .mgmtIrqOutPin(mgmtIrqOutPin), .mgmtIrqOutPinOe(mgmtIrqOutPinOe),
    .routeGroupToSerirq(routeGroupToSerirq),
    .smiWireLevel(smiWireLevel), .serirqSlot(serirqSlot));

  // Free-running clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ----
  // Tasks
  // ----
  task automatic check(input string what, input logic [7:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Write cycle, then the model takes the same effect
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk);
    regAddr   <= a;
    regWrData <= d;
    regWrStb  <= 1'b1;
    @(posedge clk);
    regWrStb  <= 1'b0;
    if (a >= OFS_STS_A && a <= OFS_STS_C)
      mReg[a-OFS_STS_A] &= ~d;
    else if (a == OFS_EN_PER)
      mReg[3] = d & WMASK_EN_PER;
    else if (a == OFS_EN_MSC)
      mReg[4] = d & WMASK_EN_MSC;
    else if (a >= OFS_EN_PA && a <= OFS_MSK_C)
      mReg[a-OFS_STS_A] = d;
  endtask : wr

  // Data is only valid in the cycle after the strobe
  task automatic rdChk(input logic [7:0] a);
    logic [7:0] e;
    e = (a >= OFS_STS_A && a <= OFS_MSK_C) ? mReg[a-OFS_STS_A] : 8'h00;
    @(posedge clk);
    regAddr  <= a;
    regRdStb <= 1'b1;
    @(posedge clk);
    regRdStb <= 1'b0;
    // Look while the data stands, clear of the edge that launched it
    #1;
    check("regRdData", regRdData, e);
  endtask : rdChk

  function automatic logic irqAct();
    return |(mReg[0] & mReg[6]) || |(mReg[1] & mReg[7])
        || |(mReg[2] & mReg[8]);
  endfunction : irqAct

  // Sources are levels, so mouse and keyboard fall only at the source
  function automatic logic groupAct();
    logic [7:0] per;
    per = {perIrq[4], 2'b00, perIrq[3:0], 1'b0};
    return |(per & mReg[3]) || |({3'b000, mscIrq} & mReg[4])
        || |(pinEventA & mReg[5]) || irqAct();
  endfunction : groupAct

  // Outputs are registered, so two edges let every change land
  task automatic checkOuts();
    logic a;
    repeat (2) @(posedge clk);
    #1;
    a = groupAct();
    check("groupMgmtIrq_n", groupMgmtIrq_n, !a);
    check("irq", irq, irqAct());
    check("serirqSlot", serirqSlot, mReg[4][6] && a);
    check("smiWireLevel", smiWireLevel, mReg[4][7] ? !a : 1'b1);
    check("pinOe", mgmtIrqOutPinOe, mReg[4][7] && (pinPushPull || a));
  endtask : checkOuts

  // Rising edges on the event pins; the sync delay is under five cycles
  task automatic pinEvents(input logic [23:0] v);
    @(posedge clk);
    {gp1x, gp5x, gpA} <= v;
    repeat (5) @(posedge clk);
    {gp1x, gp5x, gpA} <= 24'h0;
    mReg[0] |= v[7:0];
    mReg[1] |= v[15:8];
    mReg[2] |= v[23:16];
    repeat (4) @(posedge clk);
  endtask : pinEvents

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_of_test

  // Watchdog, well beyond the few hundred cycles the tests need
  initial begin
    #(8 * 20000);
    n_fail++;
    end_of_test();
  end

  // ----
  // Main sequence
  // ----
  initial begin
    {rst_n, regWrStb, regRdStb, pinPushPull} = 4'h0;
    mainRst_n = 1'b1;
    {regAddr, regWrData, gpA, gp5x, gp1x, pinEventA} = 48'h0;
    {perIrq, mscIrq} = 10'h000;
    foreach (mReg[i]) mReg[i] = 8'h00;
    void'($urandom(32'h06326df3));
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    for (int a = 8'h10; a <= 8'h1D; a++) rdChk(8'(a));
    $display("test reset_values done");
    for (int a = OFS_EN_PER; a <= OFS_MSK_C; a++) begin
      wr(8'(a), 8'hFF);
      rdChk(8'(a));
      wr(8'(a), 8'h00);
    end
    wr(8'h1C, 8'hFF);
    rdChk(8'h1C);
    $display("test register_access done");
    for (int r = 0; r < 6; r++) begin
      pinEvents(24'($urandom));
      for (int a = 0; a < 3; a++) rdChk(OFS_STS_A + 8'(a));
      wr(OFS_MSK_A + 8'(r % 3), 8'($urandom));
      checkOuts();
      for (int a = 0; a < 3; a++) begin
        wr(OFS_STS_A + 8'(a), 8'($urandom));
        rdChk(OFS_STS_A + 8'(a));
      end
      checkOuts();
    end
    $display("test pin_events done");
    @(posedge clk);
    mainRst_n <= 1'b0;
    repeat (2) @(posedge clk);
    mainRst_n <= 1'b1;
    mReg[0] = 8'h08;
    rdChk(OFS_STS_A);
    rdChk(OFS_STS_B);
    wr(OFS_MSK_A, 8'h08);
    checkOuts();
    $display("test main_reset done");
    for (int a = OFS_STS_A; a <= OFS_STS_C; a++) wr(8'(a), 8'hFF);
    for (int i = 0; i < 60; i++) begin
      @(posedge clk);
      perIrq      <= 5'($urandom & $urandom & $urandom);
      mscIrq      <= 5'($urandom & $urandom & $urandom);
      pinEventA   <= 8'($urandom & $urandom & $urandom);
      pinPushPull <= 1'($urandom);
      wr(OFS_EN_PER + 8'(i % 3), 8'($urandom));
      if (i % 7 == 0)
        wr(OFS_STS_A, 8'hFF);
      checkOuts();
    end
    $display("test group_gating done");
    end_of_test();
  end
endmodule : tb

bind smi_status_enable_group smi_group_chk smi_group_chk_inst (
  .clk, .rst_n, .regAddr, .regWrData, .regWrStb, .regRdStb, .regRdData,
  .mouseIrq, .pinPushPull, .groupMgmtIrq_n, .mgmtIrqOutPin,
  .mgmtIrqOutPinOe, .routeGroupToSerirq, .irq);
